// ==== design/ltq_defs.vh ====
`ifndef LTQ_DEFS_VH
`define LTQ_DEFS_VH
`define LTQ_CLK_PERIOD_PS 50000
`define LTQ_MIN_WINDOW_PS 2000
`define LTQ_MIN_WINDOW_CYC (((`LTQ_MIN_WINDOW_PS + `LTQ_CLK_PERIOD_PS - 1) / `LTQ_CLK_PERIOD_PS) < 1 ? 1 : ((`LTQ_MIN_WINDOW_PS + `LTQ_CLK_PERIOD_PS - 1) / `LTQ_CLK_PERIOD_PS))
`define LTQ_CNT_W 16
`define LTQ_CNT_MAX 16'hffff
`define LTQ_ONE_CNT 16'h0001
`define LTQ_ZERO_CNT 16'h0000
`define LTQ_MODE_PATTERN 2'h0
`define LTQ_MODE_TIMED 2'h1
`define LTQ_MODE_STATE 2'h2
`define LTQ_MODE_SETHOLD 2'h3
`define LTQ_FN_AND 2'h0
`define LTQ_FN_NAND 2'h1
`define LTQ_FN_OR 2'h2
`define LTQ_FN_NOR 2'h3
`define LTQ_Q_DONTCARE 2'h0
`define LTQ_Q_HIGH 2'h1
`define LTQ_Q_LOW 2'h2
`define LTQ_DEF_DATA_SEL 2'h0
`define LTQ_DEF_CLK_SEL 2'h1
`define LTQ_CLOCK_CH 3
`endif

// ==== design/ltq_sync.v ====
`timescale 1ns/1ps
`default_nettype none
module ltq_sync (
    input wire mclk,
    input wire reset_n,
    input wire async_in,
    output reg sync_out
);
    reg stage1_reg;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end
endmodule // ltq_sync
`default_nettype wire

// ==== design/ltq_qualifier.v ====
`timescale 1ns/1ps
`default_nettype none
`include "ltq_defs.vh"
// Behaviour
// - Timed pattern mode takes a time limit and a shorter/longer-than selection.
// - Wait for condition true, then time it until it goes false.
// - On going false, compare duration; trigger at that false transition.
// - Longer-than needs duration above limit; shorter-than needs it below.
// - State mode uses the fourth input as clock, condition from other three.
// - State inputs qualified high, low or don't-care; clock edge rising or falling.
// - State mode combines qualified inputs with AND, OR, NAND or NOR.
// - Polarity selects triggering on condition becoming met or becoming not met.
// - Setup/hold uses one data and one clock input; defaults first and second.
// - Setup/hold clock edge is rising or falling by a toggle setting.
// - Clock crossing instant is the edge event and window reference point.
// - Trigger when data transitions inside the setup-before/hold-after window.
// - Positive setup starts window before edge; positive hold ends it after.
// - Setup plus hold kept at 2 ns (rounded up to one 50 ns cycle) or more; hold is raised to make up the rest.
// - Negative setup or hold moves the window wholly before or after edge.
// - AND all, NAND not all, OR any, NOR none; not-met swaps pairs.
// - State mode waits for the selected clock edge, then samples and evaluates.
module ltq_qualifier (
    input wire mclk,
    input wire reset_n,
    input wire first_input,
    input wire second_input,
    input wire third_input,
    input wire fourth_input_clock,
    input wire enable,
    input wire [1:0] trig_mode,
    input wire [1:0] logic_func,
    input wire goes_false,
    input wire [7:0] input_qual,
    input wire [15:0] time_limit,
    input wire longer_than,
    input wire state_falling,
    input wire sh_use_defaults,
    input wire [1:0] sh_data_sel,
    input wire [1:0] sh_clock_sel,
    input wire sh_falling,
    input wire signed [15:0] setup_cycles,
    input wire signed [15:0] hold_cycles,
    output reg trigger,
    output reg [15:0] true_duration,
    output reg [15:0] eff_setup,
    output reg [15:0] eff_hold
);
    wire [3:0] in_sync;
    ltq_sync u_sync0 (.mclk(mclk), .reset_n(reset_n), .async_in(first_input), .sync_out(in_sync[0]));
    ltq_sync u_sync1 (.mclk(mclk), .reset_n(reset_n), .async_in(second_input), .sync_out(in_sync[1]));
    ltq_sync u_sync2 (.mclk(mclk), .reset_n(reset_n), .async_in(third_input), .sync_out(in_sync[2]));
    ltq_sync u_sync3 (.mclk(mclk), .reset_n(reset_n), .async_in(fourth_input_clock), .sync_out(in_sync[3]));

    reg [3:0] in_prev_reg;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            in_prev_reg <= 4'h0;
        end else begin
            in_prev_reg <= in_sync;
        end
    end

    // Per-input precondition; don't-care inputs are excluded from the combine
    reg [3:0] pre_ok;
    reg [3:0] pre_used;
    integer i;
    always @* begin
        pre_ok = 4'h0;
        pre_used = 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            case (input_qual[2*i +: 2])
                `LTQ_Q_HIGH: begin
                    pre_ok[i] = in_sync[i];
                    pre_used[i] = 1'b1;
                end
                `LTQ_Q_LOW: begin
                    pre_ok[i] = ~in_sync[i];
                    pre_used[i] = 1'b1;
                end
                default: begin
                    pre_ok[i] = 1'b0;
                    pre_used[i] = 1'b0;
                end
            endcase
        end
        if (trig_mode == `LTQ_MODE_STATE) begin
            pre_used[`LTQ_CLOCK_CH] = 1'b0;
            pre_ok[`LTQ_CLOCK_CH] = 1'b0;
        end
    end

    wire all_ok = ((pre_ok | ~pre_used) == 4'hf);
    wire any_ok = |(pre_ok & pre_used);
    // Goes FALSE swaps AND with NAND and OR with NOR
    wire [1:0] eff_func = goes_false ? (logic_func ^ 2'h1) : logic_func;
    reg cond;
    always @* begin
        case (eff_func)
            `LTQ_FN_AND: cond = all_ok;
            `LTQ_FN_NAND: cond = ~all_ok;
            `LTQ_FN_OR: cond = any_ok;
            `LTQ_FN_NOR: cond = ~any_ok;
            default: cond = 1'b0;
        endcase
    end

    reg cond_prev_reg;
    reg [15:0] dur_reg;
    reg [15:0] dur_next;
    always @* begin
        dur_next = dur_reg;
        if (cond && !cond_prev_reg) begin
            dur_next = `LTQ_ONE_CNT;
        end else if (cond) begin
            if (dur_reg != `LTQ_CNT_MAX) begin
                dur_next = dur_reg + `LTQ_ONE_CNT;
            end
        end
    end

    wire fell = cond_prev_reg && !cond;
    wire timed_hit = longer_than ? (dur_reg > time_limit) : (dur_reg < time_limit);

    // State mode edge on the fourth input
    wire clk4_rise = in_sync[`LTQ_CLOCK_CH] && !in_prev_reg[`LTQ_CLOCK_CH];
    wire clk4_fall = !in_sync[`LTQ_CLOCK_CH] && in_prev_reg[`LTQ_CLOCK_CH];
    wire state_edge = state_falling ? clk4_fall : clk4_rise;

    // Setup/hold source selection
    wire [1:0] dsel = sh_use_defaults ? `LTQ_DEF_DATA_SEL : sh_data_sel;
    wire [1:0] csel = sh_use_defaults ? `LTQ_DEF_CLK_SEL : sh_clock_sel;
    wire d_now = in_sync[dsel];
    wire d_prev = in_prev_reg[dsel];
    wire c_now = in_sync[csel];
    wire c_prev = in_prev_reg[csel];
    wire d_change = d_now ^ d_prev;
    wire sh_edge = sh_falling ? (c_prev && !c_now) : (!c_prev && c_now);

    // Enforce setup + hold >= minimum by raising hold to minimum minus setup
    localparam integer MIN_WIN_I = `LTQ_MIN_WINDOW_CYC;
    localparam signed [17:0] MIN_WIN = MIN_WIN_I[17:0];
    reg signed [17:0] s_eff;
    reg signed [17:0] h_eff;
    always @* begin
        s_eff = {{2{setup_cycles[15]}}, setup_cycles};
        h_eff = {{2{hold_cycles[15]}}, hold_cycles};
        if (s_eff + h_eff < MIN_WIN) begin
            h_eff = MIN_WIN - s_eff;
        end
    end

    // Time since last data change and since last clock edge, saturating
    reg [15:0] since_d_reg;
    reg [15:0] since_c_reg;
    reg c_seen_reg;
    wire signed [17:0] since_d_s = {2'b00, since_d_reg};
    wire signed [17:0] since_c_s = {2'b00, since_c_reg};
    // Setup side: data changed within window [edge - setup, edge + min(hold,0)]
    wire setup_viol = sh_edge && (s_eff >= 18'sd0) && (since_d_s < s_eff) &&
                      (h_eff >= 18'sd0 ? 1'b1 : (since_d_s >= -h_eff));
    // Hold side: data changes after the edge within window [max(-setup,0), hold]
    wire hold_viol = d_change && c_seen_reg && (h_eff >= 18'sd0) &&
                     (since_c_s <= h_eff) &&
                     (s_eff >= 18'sd0 ? 1'b1 : (since_c_s >= -s_eff));

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            since_d_reg <= `LTQ_CNT_MAX;
            since_c_reg <= `LTQ_CNT_MAX;
            c_seen_reg <= 1'b0;
        end else begin
            if (d_change) begin
                since_d_reg <= `LTQ_ZERO_CNT;
            end else if (since_d_reg != `LTQ_CNT_MAX) begin
                since_d_reg <= since_d_reg + `LTQ_ONE_CNT;
            end
            if (sh_edge) begin
                since_c_reg <= `LTQ_ONE_CNT;
                c_seen_reg <= 1'b1;
            end else if (since_c_reg != `LTQ_CNT_MAX) begin
                since_c_reg <= since_c_reg + `LTQ_ONE_CNT;
            end
        end
    end

    reg trig_next;
    always @* begin
        trig_next = 1'b0;
        if (enable) begin
            case (trig_mode)
                `LTQ_MODE_PATTERN: trig_next = cond && !cond_prev_reg;
                `LTQ_MODE_TIMED: trig_next = fell && timed_hit;
                `LTQ_MODE_STATE: trig_next = state_edge && cond;
                `LTQ_MODE_SETHOLD: trig_next = setup_viol || hold_viol;
                default: trig_next = 1'b0;
            endcase
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cond_prev_reg <= 1'b0;
            dur_reg <= `LTQ_ZERO_CNT;
            trigger <= 1'b0;
            true_duration <= `LTQ_ZERO_CNT;
            eff_setup <= `LTQ_ZERO_CNT;
            eff_hold <= `LTQ_ZERO_CNT;
        end else begin
            cond_prev_reg <= cond;
            dur_reg <= dur_next;
            trigger <= trig_next;
            if (fell) begin
                true_duration <= dur_reg;
            end
            eff_setup <= s_eff[15:0];
            eff_hold <= h_eff[15:0];
        end
    end
endmodule // ltq_qualifier
`default_nettype wire

// ==== test/ltq_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ltq_defs.vh"
module ltq_monitor (
    input wire mclk,
    input wire reset_n,
    input wire first_input,
    input wire second_input,
    input wire third_input,
    input wire fourth_input_clock,
    input wire [1:0] trig_mode,
    input wire [15:0] time_limit,
    input wire longer_than,
    input wire sh_use_defaults,
    input wire signed [15:0] setup_cycles,
    input wire signed [15:0] hold_cycles,
    input wire trigger,
    input wire [15:0] true_duration,
    input wire [15:0] eff_setup,
    input wire [15:0] eff_hold
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_timed;
        trig_mode == `LTQ_MODE_TIMED && $stable(time_limit) && $stable(longer_than);
    endsequence
    sequence s_sh_steady;
        ($stable(setup_cycles) && $stable(hold_cycles)) [*2];
    endsequence
    property p_longer; s_timed ##0 (trigger && longer_than) |-> true_duration > time_limit; endproperty
    property p_shorter; s_timed ##0 (trigger && !longer_than) |-> true_duration < time_limit; endproperty
    property p_timed_pulse; s_timed ##0 trigger |=> !trigger; endproperty
    property p_eff_sum; s_sh_steady |-> $signed(eff_setup) + $signed(eff_hold) >= 1; endproperty
    property p_eff_setup;
        s_sh_steady ##0 (setup_cycles + hold_cycles >= 1) |-> eff_setup == setup_cycles;
    endproperty
    property p_pattern_quiet;
        (trig_mode == `LTQ_MODE_PATTERN && $stable({first_input, second_input, third_input,
            fourth_input_clock})) [*6] |-> !trigger;
    endproperty
    property p_state_edge;
        (trig_mode == `LTQ_MODE_STATE && $stable(fourth_input_clock)) [*6] |-> !trigger;
    endproperty
    property p_sh_quiet;
        (trig_mode == `LTQ_MODE_SETHOLD && sh_use_defaults && $stable(first_input)
            && setup_cycles < 3 && hold_cycles < 3) [*8] |-> !trigger;
    endproperty
    a_longer: assert property (p_longer) else $error("longer trigger too short");
    a_shorter: assert property (p_shorter) else $error("shorter trigger too long");
    a_timed_pulse: assert property (p_timed_pulse) else $error("timed trigger twice");
    a_eff_sum: assert property (p_eff_sum) else $error("window below minimum");
    a_eff_setup: assert property (p_eff_setup) else $error("setup altered");
    a_pattern_quiet: assert property (p_pattern_quiet) else $error("pattern trigger idle");
    a_state_edge: assert property (p_state_edge) else $error("state trigger no edge");
    a_sh_quiet: assert property (p_sh_quiet) else $error("violation without data change");
endmodule // ltq_monitor
bind ltq_qualifier ltq_monitor ltq_monitor_inst (.mclk, .reset_n, .first_input, .second_input,
    .third_input, .fourth_input_clock, .trig_mode, .time_limit, .longer_than, .sh_use_defaults,
    .setup_cycles, .hold_cycles, .trigger, .true_duration, .eff_setup, .eff_hold);
`default_nettype wire

// ==== test/ltq_sig_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module ltq_sig_src (
    output var logic first_input,
    output var logic second_input,
    output var logic third_input,
    output var logic fourth_input_clock
);
    initial {fourth_input_clock, third_input, second_input, first_input} = 4'h0;
    task automatic set_lines(input logic [3:0] v);
        {fourth_input_clock, third_input, second_input, first_input} = v;
    endtask
    // Clock line stays quiet between bursts so only the edges asked for exist
    task automatic clk_pulse();
        fourth_input_clock = 1'b1;
        #200;
        fourth_input_clock = 1'b0;
        #200;
    endtask
endmodule // ltq_sig_src
`default_nettype wire

// ==== test/tb_logic_trigger_qualifier.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ltq_defs.vh"
module tb_logic_trigger_qualifier;
    logic mclk = 1'b0, reset_n = 1'b0, enable = 1'b1, goes_false = 1'b0, longer_than = 1'b0;
    logic state_falling = 1'b0, sh_use_defaults = 1'b1, sh_falling = 1'b0;
    logic [1:0] trig_mode = `LTQ_MODE_TIMED, logic_func = `LTQ_FN_AND;
    logic [1:0] sh_data_sel = `LTQ_DEF_DATA_SEL, sh_clock_sel = `LTQ_DEF_CLK_SEL;
    logic [7:0] input_qual = 8'h01;
    logic [15:0] time_limit = 16'h0002;
    logic signed [15:0] setup_cycles = 16'sh0002, hold_cycles = 16'sh0002;
    wire first_input, second_input, third_input, fourth_input_clock, trigger;
    wire [15:0] true_duration, eff_setup, eff_hold;
    int err_count = 0, checks_done = 0;
    initial forever #25 mclk = ~mclk;
    ltq_sig_src ltq_sig_src_inst (.first_input, .second_input, .third_input, .fourth_input_clock);
    ltq_qualifier ltq_qualifier_inst (.mclk, .reset_n, .first_input, .second_input, .third_input,
        .fourth_input_clock, .enable, .trig_mode, .logic_func, .goes_false, .input_qual,
        .time_limit, .longer_than, .state_falling, .sh_use_defaults, .sh_data_sel, .sh_clock_sel,
        .sh_falling, .setup_cycles, .hold_cycles, .trigger, .true_duration, .eff_setup, .eff_hold);
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic watch(input int n, output logic seen);
        seen = 1'b0;
        repeat (n) begin
            @(posedge mclk);
            #1 if (trigger === 1'b1) seen = 1'b1;
        end
    endtask
    task automatic timed(input logic lt, input int n, input logic et);
        logic s;
        longer_than = lt;
        ltq_sig_src_inst.set_lines(4'h1);
        repeat (n) @(negedge mclk);
        ltq_sig_src_inst.set_lines(4'h0);
        watch(8, s);
        chk("timed_trigger", {15'h0, et}, {15'h0, s});
        if (et) chk("true_duration", n[15:0], true_duration);
        @(negedge mclk);
    endtask
    task automatic eff(input logic signed [15:0] su, ho, input logic [15:0] es, eh);
        setup_cycles = su;
        hold_cycles = ho;
        repeat (3) @(negedge mclk);
        chk("eff_setup", es, eff_setup);
        chk("eff_hold", eh, eff_hold);
    endtask
    task automatic sh(input logic [3:0] v, input int n, input logic et);
        logic s;
        ltq_sig_src_inst.set_lines(v);
        repeat (n) @(negedge mclk);
        ltq_sig_src_inst.set_lines(4'h3);
        watch(10, s);
        chk("sh_trigger", {15'h0, et}, {15'h0, s});
        @(negedge mclk);
        ltq_sig_src_inst.set_lines(4'h0);
        repeat (10) @(negedge mclk);
    endtask
    initial begin
        logic s;
        repeat (10) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        timed(1'b1, 4, 1'b1);
        timed(1'b1, 2, 1'b0);
        timed(1'b0, 1, 1'b1);
        timed(1'b0, 3, 1'b0);
        enable = 1'b0;
        timed(1'b1, 5, 1'b0);
        enable = 1'b1;
        trig_mode = `LTQ_MODE_STATE;
        input_qual = 8'h09;
        ltq_sig_src_inst.set_lines(4'h3);
        for (int i = 0; i < 8; i++) begin
            logic_func = i[2:1];
            goes_false = i[0];
            repeat (3) @(negedge mclk);
            fork
                ltq_sig_src_inst.clk_pulse();
                watch(12, s);
            join
            chk("state_trigger", {15'h0, ((i[2:1] == 1) || (i[2:1] == 2)) ^ i[0]}, {15'h0, s});
        end
        // Falling edge selected: the pulse still gives one edge, NAND of unmet inputs fires
        state_falling = 1'b1;
        logic_func = `LTQ_FN_NAND;
        goes_false = 1'b0;
        repeat (3) @(negedge mclk);
        fork
            ltq_sig_src_inst.clk_pulse();
            watch(12, s);
        join
        chk("state_fall_trigger", 16'h0001, {15'h0, s});
        logic_func = `LTQ_FN_AND;
        repeat (3) @(negedge mclk);
        fork
            ltq_sig_src_inst.clk_pulse();
            watch(12, s);
        join
        chk("state_fall_and", 16'h0000, {15'h0, s});
        state_falling = 1'b0;
        trig_mode = `LTQ_MODE_SETHOLD;
        ltq_sig_src_inst.set_lines(4'h0);
        eff(16'sh0000, 16'sh0000, 16'h0000, 16'h0001);
        eff(-16'sd3, 16'sh0002, 16'hfffd, 16'h0004);
        eff(16'sh0002, 16'sh0002, 16'h0002, 16'h0002);
        sh(4'h1, 1, 1'b1);
        sh(4'h1, 6, 1'b0);
        sh(4'h2, 1, 1'b1);
        sh(4'h2, 5, 1'b0);
        report_and_stop;
    end
    initial begin
        #100us;
        err_count++;
        report_and_stop;
    end
endmodule // tb_logic_trigger_qualifier
`default_nettype wire
